// *** alarm_cfg_pkg.sv ***
// constants of the alarm filter configuration bank
// assumes a single 40 MHz clock and a plain register port of 8-bit address, 16-bit data
//
// What this block does
// - reserved bits ignore writes, read zero
// - rate-filter register at 4Dh, reset 0070h
// - rate select field in bits 9:8
// - rate codes give full, half, quarter, eighth
// - input filter count bits 7:5, inputs 0-3
// - input alarm after N runs, 1 to 256
// - temperature filter count in bits 4:3
// - temperature alarm after 1,2,4,8 samples
// - fault mask register at 4Eh, reset 0000h
// - enables gate the output, flags always set
// - overheat flag unmasked, drives output if enabled
// - bit 14 enables input 0 and pair 0/1
// - bit 13 enables input 1
// - bit 12 enables input 2 and pair 2/3
// - bit 11 enables input 3
// - masked flag sets, output stays high
// - global output enable, reset zero, gates output
package alarm_cfg_pkg;

    // ==========================================================
    // bus shape
    localparam int          ADDR_W = 8;
    localparam int          DATA_W = 16;
    localparam int          NUM_INPUTS = 4;
    localparam int          RUN_W = 9;
    localparam int          STATUS_W = 5;

    // ==========================================================
    // register offsets
    localparam logic [7:0]  RATE_FILTER_ADDR = 8'h4D;
    localparam logic [7:0]  FAULT_MASK_ADDR  = 8'h4E;
    localparam logic [7:0]  FAULT_CTRL_ADDR  = 8'h4F;
    localparam logic [7:0]  STATUS_ADDR      = 8'h50;
    localparam logic [7:0]  IRQ_MASK_ADDR    = 8'h51;

    // ==========================================================
    // reset values and writable bits
    localparam logic [15:0] RATE_FILTER_RESET = 16'h0070;
    localparam logic [15:0] RATE_FILTER_WMASK = 16'h03F8;
    localparam logic [15:0] FAULT_MASK_RESET  = 16'h0000;
    localparam logic [15:0] FAULT_MASK_WMASK  = 16'h7800;
    localparam logic [4:0]  STATUS_RESET      = 5'h00;
    localparam logic [4:0]  IRQ_MASK_RESET    = 5'h00;
    localparam logic        FAULT_CTRL_RESET  = 1'b0;

    // ==========================================================
    // field positions
    localparam int          SAMPLE_RATE_SEL_HI = 9;
    localparam int          SAMPLE_RATE_SEL_LO = 8;
    localparam int          INPUT_FILTER_HI    = 7;
    localparam int          INPUT_FILTER_LO    = 5;
    localparam int          THERMO_FILTER_HI   = 4;
    localparam int          THERMO_FILTER_LO   = 3;
    localparam int          INPUT0_FAULT_ENABLE_BIT = 14;
    localparam int          INPUT1_FAULT_ENABLE_BIT = 13;
    localparam int          INPUT2_FAULT_ENABLE_BIT = 12;
    localparam int          INPUT3_FAULT_ENABLE_BIT = 11;
    localparam int          OVERHEAT_STATUS_BIT     = 4;
    localparam int          FAULT_OUT_ENABLE_BIT    = 0;

    // ==========================================================
    // rates
    localparam int          FULL_RATE_KSPS = 500;

    // register selected by an address
    typedef enum logic [2:0]
    {
        SEL_NONE        = 3'b000,
        SEL_RATE_FILTER = 3'b001,
        SEL_FAULT_MASK  = 3'b010,
        SEL_FAULT_CTRL  = 3'b011,
        SEL_STATUS      = 3'b100,
        SEL_IRQ_MASK    = 3'b101
    } reg_sel_t;

endpackage

// *** run_filter.sv ***
// consecutive-sample run filter for one monitored quantity
// assumes sample strobes and range results come from logic on sys_clk
`timescale 1ns/100ps
module run_filter
    import alarm_cfg_pkg::*;
(
    // clock and reset
    input  wire logic               sys_clk,
    input  wire logic               srst,
    // samples
    input  wire logic               sample_valid,
    input  wire logic               out_of_range,
    input  wire logic [RUN_W-1:0]   run_len,
    // result
    output logic                    hit
);

    logic [RUN_W-1:0]   count_reg;
    logic [RUN_W-1:0]   count_next;
    logic               hit_next;

    // ==========================================================
    // run counting
    // counter saturates at run_len so a long fault keeps reporting
    always_comb
    begin
        count_next = count_reg;
        hit_next   = 1'b0;
        if (sample_valid)
        begin
            if (!out_of_range)
            begin
                count_next = '0;
            end
            else if (count_reg + RUN_W'(1) >= run_len)
            begin
                count_next = run_len;
                hit_next   = 1'b1;
            end
            else
            begin
                count_next = count_reg + RUN_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            count_reg <= '0;
            hit       <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            hit       <= hit_next;
        end
    end

    // ==========================================================
    // checks
    a_good_sample_clears: assert property (@(posedge sys_clk) disable iff (srst)
        sample_valid && !out_of_range |=> count_reg == '0 && !hit)
        else $error("run counter not cleared by in-range sample");

    a_run_reaches_hit: assert property (@(posedge sys_clk) disable iff (srst)
        sample_valid && out_of_range && (count_reg + RUN_W'(1) >= run_len) |=> hit)
        else $error("completed run did not raise hit");

    a_hit_needs_fault: assert property (@(posedge sys_clk) disable iff (srst)
        hit |-> $past(sample_valid) && $past(out_of_range))
        else $error("hit without an out-of-range sample");

endmodule

// *** alarm_filter_bank.sv ***
// register bank, alarm filters and fault output of the monitor alarm path
// assumes range results arrive on sys_clk and a register master that never waits
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/100ps
module alarm_filter_bank
    import alarm_cfg_pkg::*;
(
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   srst,
    // register port
    input  wire logic [ADDR_W-1:0]      reg_addr,
    input  wire logic [DATA_W-1:0]      reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [DATA_W-1:0]      reg_rdata,
    // range results of inputs 0 to 3
    input  wire logic [NUM_INPUTS-1:0]  input_sample_valid,
    input  wire logic [NUM_INPUTS-1:0]  input_out_of_range,
    // range result of the temperature monitor
    input  wire logic                   thermo_sample_valid,
    input  wire logic                   thermo_out_of_limit,
    // converter pacing
    output logic      [3:0]             sample_rate_div,
    // alarm outputs
    output logic                        fault_n,
    output logic                        irq
);

    // ==========================================================
    // decode helpers
    function automatic reg_sel_t decode_addr(input logic [ADDR_W-1:0] addr);
        case (addr)
            RATE_FILTER_ADDR: decode_addr = SEL_RATE_FILTER;
            FAULT_MASK_ADDR:  decode_addr = SEL_FAULT_MASK;
            FAULT_CTRL_ADDR:  decode_addr = SEL_FAULT_CTRL;
            STATUS_ADDR:      decode_addr = SEL_STATUS;
            IRQ_MASK_ADDR:    decode_addr = SEL_IRQ_MASK;
            default:          decode_addr = SEL_NONE;
        endcase
    endfunction

    // divider relative to the full 500 kSPS rate
    function automatic logic [3:0] rate_divider(input logic [1:0] code);
        case (code)
            2'h0:    rate_divider = 4'h1;
            2'h1:    rate_divider = 4'h2;
            2'h2:    rate_divider = 4'h4;
            2'h3:    rate_divider = 4'h8;
            default: rate_divider = 4'h1;
        endcase
    endfunction

    function automatic logic [RUN_W-1:0] input_run_len(input logic [2:0] code);
        case (code)
            3'h0:    input_run_len = 9'h001;
            3'h1:    input_run_len = 9'h004;
            3'h2:    input_run_len = 9'h008;
            3'h3:    input_run_len = 9'h010;
            3'h4:    input_run_len = 9'h020;
            3'h5:    input_run_len = 9'h040;
            3'h6:    input_run_len = 9'h080;
            3'h7:    input_run_len = 9'h100;
            default: input_run_len = 9'h010;
        endcase
    endfunction

    function automatic logic [RUN_W-1:0] thermo_run_len(input logic [1:0] code);
        case (code)
            2'h0:    thermo_run_len = 9'h001;
            2'h1:    thermo_run_len = 9'h002;
            2'h2:    thermo_run_len = 9'h004;
            2'h3:    thermo_run_len = 9'h008;
            default: thermo_run_len = 9'h004;
        endcase
    endfunction

    // ==========================================================
    // signals
    logic [DATA_W-1:0]      rate_filter_reg;
    logic [DATA_W-1:0]      fault_mask_reg;
    logic                   fault_ctrl_reg;
    logic [STATUS_W-1:0]    status_reg;
    logic [STATUS_W-1:0]    status_next;
    logic [STATUS_W-1:0]    irq_mask_reg;
    logic [STATUS_W-1:0]    status_clear;
    logic [STATUS_W-1:0]    hit_vec;
    logic [NUM_INPUTS-1:0]  input_enable;
    logic [1:0]             sample_rate_sel;
    logic [2:0]             input_filter_count;
    logic [1:0]             thermo_filter_count;
    logic [RUN_W-1:0]       input_len;
    logic [RUN_W-1:0]       thermo_len;
    logic                   fault_active;
    reg_sel_t               wr_sel;
    reg_sel_t               rd_sel;
    logic [DATA_W-1:0]      rdata_next;

    assign wr_sel = reg_wr ? decode_addr(reg_addr) : SEL_NONE;
    assign rd_sel = reg_rd ? decode_addr(reg_addr) : SEL_NONE;

    // ==========================================================
    // field views
    assign sample_rate_sel     = rate_filter_reg[SAMPLE_RATE_SEL_HI:SAMPLE_RATE_SEL_LO];
    assign input_filter_count  = rate_filter_reg[INPUT_FILTER_HI:INPUT_FILTER_LO];
    assign thermo_filter_count = rate_filter_reg[THERMO_FILTER_HI:THERMO_FILTER_LO];
    assign input_len           = input_run_len(input_filter_count);
    assign thermo_len          = thermo_run_len(thermo_filter_count);

    // per-input enable; inputs 0 and 2 also cover their differential pairs
    assign input_enable[0] = fault_mask_reg[INPUT0_FAULT_ENABLE_BIT];
    assign input_enable[1] = fault_mask_reg[INPUT1_FAULT_ENABLE_BIT];
    assign input_enable[2] = fault_mask_reg[INPUT2_FAULT_ENABLE_BIT];
    assign input_enable[3] = fault_mask_reg[INPUT3_FAULT_ENABLE_BIT];

    // ==========================================================
    // configuration registers
    // only writable bits are stored, so reserved bits can never read back as one
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            rate_filter_reg <= RATE_FILTER_RESET;
        end
        else if (wr_sel == SEL_RATE_FILTER)
        begin
            rate_filter_reg <= reg_wdata & RATE_FILTER_WMASK;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            fault_mask_reg <= FAULT_MASK_RESET;
        end
        else if (wr_sel == SEL_FAULT_MASK)
        begin
            fault_mask_reg <= reg_wdata & FAULT_MASK_WMASK;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            fault_ctrl_reg <= FAULT_CTRL_RESET;
        end
        else if (wr_sel == SEL_FAULT_CTRL)
        begin
            fault_ctrl_reg <= reg_wdata[FAULT_OUT_ENABLE_BIT];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            irq_mask_reg <= IRQ_MASK_RESET;
        end
        else if (wr_sel == SEL_IRQ_MASK)
        begin
            irq_mask_reg <= reg_wdata[STATUS_W-1:0];
        end
    end

    // ==========================================================
    // run filters
    genvar gi;
    generate
        for (gi = 0; gi < NUM_INPUTS; gi = gi + 1)
        begin : g_input
            run_filter u_filter
            (
                .sys_clk      (sys_clk),
                .srst         (srst),
                .sample_valid (input_sample_valid[gi]),
                .out_of_range (input_out_of_range[gi]),
                .run_len      (input_len),
                .hit          (hit_vec[gi])
            );
        end
    endgenerate

    run_filter u_thermo_filter
    (
        .sys_clk      (sys_clk),
        .srst         (srst),
        .sample_valid (thermo_sample_valid),
        .out_of_range (thermo_out_of_limit),
        .run_len      (thermo_len),
        .hit          (hit_vec[OVERHEAT_STATUS_BIT])
    );

    // ==========================================================
    // sticky status, write one to clear
    // a hit in the clearing cycle wins, so no event is ever dropped
    assign status_clear = (wr_sel == SEL_STATUS) ? reg_wdata[STATUS_W-1:0] : '0;
    assign status_next  = (status_reg & ~status_clear) | hit_vec;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            status_reg <= STATUS_RESET;
        end
        else
        begin
            status_reg <= status_next;
        end
    end

    // ==========================================================
    // fault output and interrupt
    // overheat bypasses the enables; the fault output waits on the global enable, irq does not
    assign fault_active = fault_ctrl_reg
                        && ((|(status_reg[NUM_INPUTS-1:0] & input_enable))
                        || status_reg[OVERHEAT_STATUS_BIT]);

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            fault_n <= 1'b1;
        end
        else
        begin
            fault_n <= !fault_active;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(status_reg & irq_mask_reg);
        end
    end

    // ==========================================================
    // converter pacing
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            sample_rate_div <= 4'h1;
        end
        else
        begin
            sample_rate_div <= rate_divider(sample_rate_sel);
        end
    end

    // ==========================================================
    // read port, data one cycle after the strobe
    always_comb
    begin
        rdata_next = '0;
        case (rd_sel)
            SEL_RATE_FILTER: rdata_next = rate_filter_reg;
            SEL_FAULT_MASK:  rdata_next = fault_mask_reg;
            SEL_FAULT_CTRL:  rdata_next = {15'h0000, fault_ctrl_reg};
            SEL_STATUS:      rdata_next = {11'h000, status_reg};
            SEL_IRQ_MASK:    rdata_next = {11'h000, irq_mask_reg};
            default:         rdata_next = '0;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            reg_rdata <= '0;
        end
        else
        begin
            reg_rdata <= rdata_next;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    a_rate_reserved_zero: assert property (
        reg_rd && reg_addr == RATE_FILTER_ADDR |=> (reg_rdata & ~RATE_FILTER_WMASK) == '0)
        else $error("reserved bit of rate register read as one");

    a_mask_reserved_zero: assert property (
        reg_rd && reg_addr == FAULT_MASK_ADDR |=> (reg_rdata & ~FAULT_MASK_WMASK) == '0)
        else $error("reserved bit of mask register read as one");

    a_rate_reset_value: assert property (
        $past(srst) |-> rate_filter_reg == RATE_FILTER_RESET)
        else $error("rate register wrong after reset");

    a_mask_reset_value: assert property (
        $past(srst) |-> fault_mask_reg == FAULT_MASK_RESET && fault_n)
        else $error("mask register wrong after reset");

    a_rate_write_fields: assert property (
        reg_wr && reg_addr == RATE_FILTER_ADDR
        |=> rate_filter_reg == ($past(reg_wdata) & RATE_FILTER_WMASK))
        else $error("rate register write not stored");

    a_rate_divider_map: assert property (
        reg_wr && reg_addr == RATE_FILTER_ADDR && reg_wdata[9:8] == 2'h2
        |=> ##1 sample_rate_div == 4'h4)
        else $error("quarter rate not decoded");

    a_flag_despite_mask: assert property (
        hit_vec[0] && !input_enable[0] |=> status_reg[0])
        else $error("masked event did not set its flag");

    a_masked_output_high: assert property (
        (status_reg[NUM_INPUTS-1:0] & input_enable) == '0 && !status_reg[OVERHEAT_STATUS_BIT]
        |=> fault_n)
        else $error("fault output low with no enabled flag");

    a_overheat_unmasked: assert property (
        status_reg[OVERHEAT_STATUS_BIT] && fault_ctrl_reg |=> !fault_n)
        else $error("overheat flag did not drive the fault output");

    a_global_disable: assert property (
        !fault_ctrl_reg |=> fault_n)
        else $error("fault output low while globally disabled");

    a_input2_enable: assert property (
        fault_ctrl_reg && status_reg[2] && fault_mask_reg[INPUT2_FAULT_ENABLE_BIT] |=> !fault_n)
        else $error("input 2 enable did not drive the fault output");

    c_rate_write: cover property (reg_wr && reg_addr == RATE_FILTER_ADDR);
    c_input_fault: cover property (hit_vec[1] ##1 status_reg[1] ##1 !fault_n);
    c_overheat: cover property (hit_vec[OVERHEAT_STATUS_BIT] ##2 !fault_n);
    c_irq_raised: cover property (!irq ##1 irq);

endmodule

// *** host_model.sv ***
// register-port master standing in for the host processor
// assumes it shares sys_clk with the bank and never meets a wait state
`timescale 1ns/100ps
module host_model
    import alarm_cfg_pkg::*;
(
    // clock
    input  wire logic               sys_clk,
    // register port
    output logic [ADDR_W-1:0]       reg_addr,
    output logic [DATA_W-1:0]       reg_wdata,
    output logic                    reg_wr,
    output logic                    reg_rd
);
    // ==========================================================
    // bus cycles
    initial
    begin
        reg_addr  = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // released lines show the inverse, so a stale value never reads as valid
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
    endtask
endmodule

// *** alarm_filter_bank_tb.sv ***
// self-checking bench of the alarm filter bank
// assumes host_model drives the register port; the bench drives range results
`timescale 1ns/100ps
module alarm_filter_bank_tb
    import alarm_cfg_pkg::*;
;

    localparam int          TIME_LIMIT = 10000;
    logic                   sys_clk;
    logic                   srst;
    logic [ADDR_W-1:0]      reg_addr;
    logic [DATA_W-1:0]      reg_wdata;
    logic                   reg_wr;
    logic                   reg_rd;
    logic [DATA_W-1:0]      reg_rdata;
    logic [NUM_INPUTS-1:0]  input_sample_valid;
    logic [NUM_INPUTS-1:0]  input_out_of_range;
    logic                   thermo_sample_valid;
    logic                   thermo_out_of_limit;
    logic [3:0]             sample_rate_div;
    logic                   fault_n;
    logic                   irq;
    logic                   rd_seen;
    logic [31:0]            rnd;
    logic [15:0]            exp_q[$];
    int                     errors;
    int                     check_count;
    int                     cycles;
    int                     ch;
    int                     n;

    // ==========================================================
    // instances
    alarm_filter_bank uut (.sys_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .input_sample_valid, .input_out_of_range, .thermo_sample_valid,
        .thermo_out_of_limit, .sample_rate_div, .fault_n, .irq);
    host_model host (.sys_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);

    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // ==========================================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        if (errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic rd_expect(input logic [7:0] a, input logic [15:0] exp);
        exp_q.push_back(exp);
        host.rd(a);
    endtask

    // channel 4 is the temperature monitor; range lines carry noise while idle
    task automatic feed(input int c, input logic bad, input int cnt);
        logic [4:0] v;
        v = 5'h01 << c;
        repeat (cnt)
        begin
            @(posedge sys_clk);
            {thermo_sample_valid, input_sample_valid} <= v;
            {thermo_out_of_limit, input_out_of_range} <= bad ? 5'h1F : 5'h00;
        end
        @(posedge sys_clk);
        {thermo_sample_valid, input_sample_valid} <= 5'h00;
        {thermo_out_of_limit, input_out_of_range} <= rnd[4:0];
    endtask

    // status lands two cycles after a sample, the outputs one later
    task automatic settle();
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    // ==========================================================
    // monitors
    always @(posedge sys_clk)
        rd_seen <= reg_rd;

    always @(negedge sys_clk)
        if (rd_seen)
            check(reg_rdata, exp_q.pop_front());

    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == TIME_LIMIT)
        begin
            errors++;
            report_and_stop();
        end
    end

    // ==========================================================
    // main sequence
    initial
    begin
        srst = 1'b1;
        input_sample_valid = 4'h0;
        input_out_of_range = 4'h0;
        thermo_sample_valid = 1'b0;
        thermo_out_of_limit = 1'b0;
        rd_seen = 1'b0;
        rnd = 32'h00000041;
        errors = 0;
        check_count = 0;
        cycles = 0;
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        rd_expect(8'h4D, 16'h0070);
        rd_expect(8'h4E, 16'h0000);
        rd_expect(8'h4F, 16'h0000);
        @(negedge sys_clk);
        check(16'(sample_rate_div), 16'h0001);
        check(16'(fault_n), 16'h0001);
        repeat (4)
        begin
            rnd = xs(rnd);
            host.wr(8'h4D, rnd[15:0]);
            rd_expect(8'h4D, rnd[15:0] & 16'h03F8);
            host.wr(8'h4E, rnd[31:16]);
            rd_expect(8'h4E, rnd[31:16] & 16'h7800);
        end
        host.wr(8'h4C, 16'hFFFF);
        rd_expect(8'h4C, 16'h0000);
        for (int c = 0; c < 4; c++)
        begin
            host.wr(8'h4D, 16'(c) << 8);
            settle();
            check(16'(sample_rate_div), 16'h0001 << c);
        end
        // eight input codes, then four temperature codes
        for (int k = 0; k < 12; k++)
        begin
            ch = (k < 8) ? k % 4 : 4;
            n = (k < 8) ? ((k == 0) ? 1 : (2 << k)) : (1 << (k - 8));
            host.wr(8'h4D, (k < 8) ? 16'(k) << 5 : 16'(k - 8) << 3);
            repeat (2)
            begin
                feed(ch, 1'b0, 1);
                feed(ch, 1'b1, n - 1);
            end
            settle();
            rd_expect(8'h50, 16'h0000);
            feed(ch, 1'b1, 1);
            settle();
            rd_expect(8'h50, 16'h0001 << ch);
            host.wr(8'h50, 16'h001F);
        end
        host.wr(8'h4D, 16'h0000);
        feed(4, 1'b1, 1);
        settle();
        check(16'(fault_n), 16'h0001);
        host.wr(8'h4F, 16'h0001);
        settle();
        check(16'(fault_n), 16'h0000);
        host.wr(8'h50, 16'h0010);
        settle();
        check(16'(fault_n), 16'h0001);
        // all other inputs enabled, so only the right bit may pass the fault
        for (int i = 0; i < 4; i++)
        begin
            host.wr(8'h4E, 16'h7800 & ~(16'h4000 >> i));
            feed(i, 1'b1, 1);
            settle();
            check(16'(fault_n), 16'h0001);
            rd_expect(8'h50, 16'h0001 << i);
            host.wr(8'h4E, 16'h4000 >> i);
            settle();
            check(16'(fault_n), 16'h0000);
            host.wr(8'h50, 16'h000F);
        end
        feed(2, 1'b1, 1);
        settle();
        check(16'(irq), 16'h0000);
        host.wr(8'h51, 16'h0004);
        settle();
        check(16'(irq), 16'h0001);
        host.wr(8'h50, 16'h0004);
        settle();
        check(16'(irq), 16'h0000);
        // live alarms with only input 1 enabled, then a reset in mid-run
        host.wr(8'h4E, 16'h2000);
        feed(1, 1'b1, 1);
        settle();
        check(16'(fault_n), 16'h0000);
        feed(4, 1'b1, 1);
        settle();
        @(posedge sys_clk);
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        @(negedge sys_clk);
        check(16'(fault_n), 16'h0001);
        rd_expect(8'h4D, 16'h0070);
        rd_expect(8'h4E, 16'h0000);
        rd_expect(8'h4F, 16'h0000);
        report_and_stop();
    end
endmodule
